//--- rtl/barrier_pkg.sv
// Purpose: shared constants and types for the memory barrier ordering block
// Assumes: kind masks use bit 0 for loads and bit 1 for stores
// Notes: counters are narrow; the issue logic stalls a kind whose counter is full
package barrier_pkg;

  // barrier type field position inside the barrier instruction word
  localparam int unsigned STYPE_MSB = 10;
  localparam int unsigned STYPE_LSB = 6;

  // barrier type codes with behaviour of their own
  localparam logic [4:0] STYPE_FULL = 5'h00;
  localparam logic [4:0] STYPE_STORE_ORDER = 5'h04;
  localparam logic [4:0] STYPE_FULL_ORDER = 5'h10;
  localparam logic [4:0] STYPE_ACQUIRE = 5'h11;
  localparam logic [4:0] STYPE_RELEASE = 5'h12;
  localparam logic [4:0] STYPE_LOAD_ORDER = 5'h13;

  // access kind masks
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_LOAD = 2'h1;
  localparam logic [1:0] KIND_STORE = 2'h2;
  localparam logic [1:0] KIND_BOTH = 2'h3;

  // outstanding access counters
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;

  // operations offered by the issue stage
  typedef enum logic [2:0] {
    OP_LOAD = 3'b000,
    OP_STORE = 3'b001,
    OP_CACHE = 3'b010,
    OP_PREFETCH = 3'b011,
    OP_INDEXED_PREFETCH = 3'b100,
    OP_BARRIER = 3'b101
  } mem_op_e;

  // memory access type of an access
  typedef enum logic [1:0] {
    CCA_UNCACHED = 2'b00,
    CCA_COHERENT = 2'b01,
    CCA_NONCOHERENT = 2'b10,
    CCA_OTHER = 2'b11
  } cca_e;

  // barrier sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } barrier_state_e;

  // what a decoded barrier demands
  typedef struct packed {
    logic [1:0] older_ord; // older kinds that must reach the ordering point
    logic [1:0] younger;   // younger kinds held until completion
    logic [1:0] older_gp;  // older kinds that must be globally performed
  } barrier_masks_s;

  localparam barrier_masks_s MASKS_RESET = 6'h00;

  // kind of a memory operation; maintenance and prefetch count as both
  function automatic logic [1:0] op_kind(input mem_op_e op);
    case (op)
      OP_LOAD: op_kind = KIND_LOAD;
      OP_STORE: op_kind = KIND_STORE;
      OP_CACHE, OP_PREFETCH, OP_INDEXED_PREFETCH: op_kind = KIND_BOTH;
      default: op_kind = KIND_NONE;
    endcase
  endfunction

  // only shared uncached or cached coherent accesses are synchronizable
  function automatic logic is_sync(input cca_e cca, input logic shared);
    is_sync = shared && (cca == CCA_UNCACHED || cca == CCA_COHERENT);
  endfunction

endpackage

//--- rtl/track_if.sv
// Purpose: carries one access kind's events and status between control and tracker
// Assumes: all signals sampled on the core clock
// Notes: one instance per access kind
`timescale 1ns/1ps
interface track_if;
  logic inc;      // a synchronizable access of this kind issued
  logic ord_dec;  // one reached the ordering point
  logic gp_dec;   // one became globally performed
  logic snap;     // barrier taken: freeze current counts as older
  logic ord_pend; // older ones still short of the ordering point
  logic gp_pend;  // older ones still not globally performed
  logic full;     // counter saturated, stop issuing this kind

  modport tracker (input inc, ord_dec, gp_dec, snap, output ord_pend, gp_pend, full);
  modport ctrl (output inc, ord_dec, gp_dec, snap, input ord_pend, gp_pend, full);
endinterface

//--- rtl/access_tracker.sv
// Purpose: counts outstanding accesses of one kind and the older ones at a barrier
// Assumes: done events of one kind are reported in issue order
// Notes: older counts drain on done events after the snapshot
`timescale 1ns/1ps
module access_tracker
  import barrier_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  track_if.tracker trk
);

  logic [CNT_W-1:0] ord_cnt; // issued, not yet at the ordering point
  logic [CNT_W-1:0] gp_cnt;  // issued, not yet globally performed
  logic [CNT_W-1:0] ord_old; // older than the active barrier
  logic [CNT_W-1:0] gp_old;

  // drop one on a done event, never below zero
  function automatic logic [CNT_W-1:0] drain(input logic [CNT_W-1:0] c, input logic d);
    drain = (d && c != CNT_ZERO) ? c - CNT_ONE : c;
  endfunction

  // running counts of everything in flight
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ord_cnt <= CNT_ZERO;
      gp_cnt <= CNT_ZERO;
    end else begin
      ord_cnt <= drain(ord_cnt, trk.ord_dec) + {{(CNT_W-1){1'b0}}, trk.inc};
      gp_cnt <= drain(gp_cnt, trk.gp_dec) + {{(CNT_W-1){1'b0}}, trk.inc};
    end
  end

  // older counts: snapshot at barrier take, then drain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ord_old <= CNT_ZERO;
      gp_old <= CNT_ZERO;
    end else if (trk.snap) begin
      ord_old <= drain(ord_cnt, trk.ord_dec);
      gp_old <= drain(gp_cnt, trk.gp_dec);
    end else begin
      ord_old <= drain(ord_old, trk.ord_dec);
      gp_old <= drain(gp_old, trk.gp_dec);
    end
  end

  assign trk.ord_pend = (ord_old != CNT_ZERO);
  assign trk.gp_pend = (gp_old != CNT_ZERO);
  // gp count is never below ord count, so it alone bounds overflow
  assign trk.full = (gp_cnt == CNT_MAX);

endmodule

//--- rtl/barrier_type_decode.sv
// Purpose: turns a five-bit barrier type into older and younger kind masks
// Assumes: purely combinational
// Notes: codes without behaviour of their own act as the full completion barrier
`timescale 1ns/1ps
module barrier_type_decode
  import barrier_pkg::*;
(
  input wire logic [4:0] stype,
  output barrier_masks_s masks
);

  // one row per type code
  always_comb begin
    case (stype)
      STYPE_STORE_ORDER: masks = '{older_ord: KIND_STORE, younger: KIND_STORE,
                                  older_gp: KIND_NONE};
      STYPE_FULL_ORDER: masks = '{older_ord: KIND_BOTH, younger: KIND_BOTH,
                                 older_gp: KIND_NONE};
      STYPE_ACQUIRE: masks = '{older_ord: KIND_LOAD, younger: KIND_BOTH,
                              older_gp: KIND_NONE};
      STYPE_RELEASE: masks = '{older_ord: KIND_BOTH, younger: KIND_STORE,
                              older_gp: KIND_NONE};
      STYPE_LOAD_ORDER: masks = '{older_ord: KIND_LOAD, younger: KIND_LOAD,
                                 older_gp: KIND_NONE};
      // type zero, vendor codes and reserved codes: full completion
      default: masks = '{older_ord: KIND_BOTH, younger: KIND_BOTH,
                        older_gp: KIND_BOTH};
    endcase
  end

endmodule

//--- rtl/memory_barrier_ordering.sv
// Purpose: barrier control in front of the load/store datapath
// Assumes: the datapath takes every issued access; done pulses only for
//   synchronizable accesses and in issue order per kind
// Notes: one-entry hold keeps younger accesses in program order
`timescale 1ns/1ps
module memory_barrier_ordering
  import barrier_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [2:0] in_op,
  input wire logic [31:0] in_instr,
  input wire logic [1:0] in_cca,
  input wire logic in_shared,
  output logic out_valid,
  output logic out_is_load,
  output logic out_is_store,
  output logic out_sync,
  output logic [31:0] out_instr,
  input wire logic ord_load_done,
  input wire logic ord_store_done,
  input wire logic gp_load_done,
  input wire logic gp_store_done,
  output logic barrier_busy,
  output logic barrier_done,
  output logic [4:0] barrier_stype,
  output logic younger_held
);

  // per-kind tracking links
  track_if ld_trk ();
  track_if st_trk ();

  // sequencer state
  barrier_state_e state;
  barrier_state_e next_state;

  // masks of the barrier now in force
  barrier_masks_s act_masks;

  // hold entry: an access or barrier that could not proceed
  logic hold_valid;
  mem_op_e hold_op;
  logic [31:0] hold_instr;
  cca_e hold_cca;
  logic hold_shared;

  // candidate for this cycle: the hold entry, else a fresh input
  logic cand_valid;
  mem_op_e cand_op;
  logic [31:0] cand_instr;
  cca_e cand_cca;
  logic cand_shared;

  // decoded view of the candidate
  logic [1:0] cand_kind;
  logic cand_sync;
  logic cand_barrier;
  barrier_masks_s cand_masks;

  // per-cycle decisions
  logic met;          // active barrier condition satisfied
  logic blocked;      // candidate access must wait for the barrier
  logic kind_full;    // a counter for the candidate kind is saturated
  logic do_issue;     // candidate access goes to the datapath
  logic do_take;      // candidate barrier is taken
  logic consume;      // candidate leaves this stage
  logic next_hold_valid;

  // candidate selection; in_ready high means the hold is empty
  always_comb begin
    if (hold_valid) begin
      cand_valid = 1'b1;
      cand_op = hold_op;
      cand_instr = hold_instr;
      cand_cca = hold_cca;
      cand_shared = hold_shared;
    end else begin
      cand_valid = in_valid && in_ready;
      cand_op = mem_op_e'(in_op);
      cand_instr = in_instr;
      cand_cca = cca_e'(in_cca);
      cand_shared = in_shared;
    end
  end

  // classify the candidate
  always_comb begin
    cand_kind = op_kind(cand_op);
    // non-synchronizable accesses pass any barrier freely
    cand_sync = is_sync(cand_cca, cand_shared);
    cand_barrier = (cand_op == OP_BARRIER);
  end

  // type field taken straight from the instruction word
  barrier_type_decode u_decode (
    .stype (cand_instr[STYPE_MSB:STYPE_LSB]),
    .masks (cand_masks)
  );

  // barrier condition: older kinds drained to the point the type demands;
  // gp pending only matters for the completion form
  always_comb begin
    met = 1'b1;
    if (|(act_masks.older_ord & {st_trk.ord_pend, ld_trk.ord_pend})) begin
      met = 1'b0;
    end
    if (|(act_masks.older_gp & {st_trk.gp_pend, ld_trk.gp_pend})) begin
      met = 1'b0;
    end
  end

  // issue decision for the candidate
  always_comb begin
    // younger constrained kinds wait while a barrier is open
    blocked = (state == ST_WAIT) && cand_sync && (|(cand_kind & act_masks.younger));
    // a full counter would lose track, so stall that kind briefly
    kind_full = (cand_kind[0] && ld_trk.full) || (cand_kind[1] && st_trk.full);
    do_issue = cand_valid && !cand_barrier && !blocked && !kind_full;
    // a second barrier waits until the first one completes
    do_take = cand_valid && cand_barrier && (state == ST_IDLE);
    consume = do_issue || do_take;
    next_hold_valid = cand_valid && !consume;
  end

  // tracker events; only synchronizable accesses are counted
  always_comb begin
    ld_trk.inc = do_issue && cand_sync && cand_kind[0];
    st_trk.inc = do_issue && cand_sync && cand_kind[1];
    ld_trk.ord_dec = ord_load_done;
    st_trk.ord_dec = ord_store_done;
    // load completion means register written; store means visible to all
    ld_trk.gp_dec = gp_load_done;
    st_trk.gp_dec = gp_store_done;
    // freezing counts at take splits older from younger
    ld_trk.snap = do_take;
    st_trk.snap = do_take;
  end

  // one tracker per access kind
  access_tracker u_load_trk (
    .core_clk (core_clk),
    .arst_n (arst_n),
    .trk (ld_trk.tracker)
  );

  access_tracker u_store_trk (
    .core_clk (core_clk),
    .arst_n (arst_n),
    .trk (st_trk.tracker)
  );

  // next state of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (do_take) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // completion releases held accesses from the next cycle on
        if (met) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // masks of the active barrier, loaded at take
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_masks <= MASKS_RESET;
      barrier_stype <= STYPE_FULL;
    end else if (do_take) begin
      // unknown and reserved codes already decode as full completion
      act_masks <= cand_masks;
      barrier_stype <= cand_instr[STYPE_MSB:STYPE_LSB];
    end
  end

  // hold entry: keeps a waiting candidate so order is never broken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_valid <= 1'b0;
      hold_op <= OP_LOAD;
      hold_instr <= 32'h0000_0000;
      hold_cca <= CCA_UNCACHED;
      hold_shared <= 1'b0;
    end else begin
      hold_valid <= next_hold_valid;
      if (!hold_valid && next_hold_valid) begin
        hold_op <= cand_op;
        hold_instr <= cand_instr;
        hold_cca <= cand_cca;
        hold_shared <= cand_shared;
      end
    end
  end

  // input ready: registered, high only when the hold will be empty
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= !next_hold_valid;
    end
  end

  // access toward the datapath; it never reorders past the ordering
  // point, so older external requests perform first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_is_load <= 1'b0;
      out_is_store <= 1'b0;
      out_sync <= 1'b0;
      out_instr <= 32'h0000_0000;
    end else begin
      out_valid <= do_issue;
      if (do_issue) begin
        out_is_load <= cand_kind[0];
        out_is_store <= cand_kind[1];
        out_sync <= cand_sync;
        out_instr <= cand_instr;
      end
    end
  end

  // barrier status seen by the pipeline; fetches never wait on it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      barrier_busy <= 1'b0;
      barrier_done <= 1'b0;
    end else begin
      barrier_busy <= (next_state == ST_WAIT);
      barrier_done <= (state == ST_WAIT) && met;
    end
  end

  // held flag: an access or barrier is waiting in the hold
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      younger_held <= 1'b0;
    end else begin
      younger_held <= next_hold_valid;
    end
  end

endmodule

//--- test/memory_barrier_ordering_properties.sv
// Purpose: port-level timing checks for the barrier block
// Assumes: one core clock, asynchronous active-low reset
// Notes: younger ops are judged by busy seen at two edges, so an older op
//   issued on the take edge is not taken for a younger one
`timescale 1ns/1ps
module memory_barrier_ordering_properties
  import barrier_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [2:0] in_op,
  input wire logic [31:0] in_instr,
  input wire logic [1:0] in_cca,
  input wire logic in_shared,
  input wire logic out_valid,
  input wire logic out_is_load,
  input wire logic out_is_store,
  input wire logic out_sync,
  input wire logic [31:0] out_instr,
  input wire logic ord_load_done,
  input wire logic ord_store_done,
  input wire logic gp_load_done,
  input wire logic gp_store_done,
  input wire logic barrier_busy,
  input wire logic barrier_done,
  input wire logic [4:0] barrier_stype,
  input wire logic younger_held
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic take_b; // barrier accepted at this edge
  logic take_m; // memory op accepted at this edge
  logic [4:0] instr_ty; // type field of the offered word
  logic [1:0] ym; // younger kinds {store, load} held by the open barrier
  // a barrier offered while another is open waits in the hold, so it is not taken
  assign take_b = in_valid && in_ready && (in_op == 3'h5) && !barrier_busy;
  assign take_m = in_valid && in_ready && (in_op != 3'h5);
  assign instr_ty = in_instr[10:6];
  // own lookup, kept apart from the decoder it checks
  always_comb begin
    case (barrier_stype)
      5'h04, 5'h12: ym = 2'h2; // stores only
      5'h13: ym = 2'h1; // loads only
      default: ym = 2'h3; // full, acquire, full ordering, unassigned codes
    endcase
  end
  stype_field_a: assert property (take_b |=> barrier_stype == $past(instr_ty))
    else $error("barrier type not taken from bits 10 to 6");
  young_order_a: assert property (
    barrier_busy && $past(barrier_busy) && out_valid && out_sync |->
      !(out_is_load && ym[0]) && !(out_is_store && ym[1]))
    else $error("younger access passed an open barrier");
  done_pulse_a: assert property (barrier_done |=> !barrier_done)
    else $error("completion pulse longer than one cycle");
  done_end_a: assert property (barrier_done |-> !barrier_busy && $past(barrier_busy))
    else $error("completion without an open barrier");
  min_latency_a: assert property (take_b |=> barrier_busy && !barrier_done)
    else $error("barrier not opened one cycle after take");
  barrier_silent_a: assert property (take_b |=> !out_valid)
    else $error("barrier issued to the datapath");
  hold_ready_a: assert property (younger_held |-> !in_ready)
    else $error("ready while the hold is full");
  issue_lat_a: assert property (take_m && !barrier_busy |=> out_valid || younger_held)
    else $error("free op neither issued nor held");
  release_a: assert property ($rose(barrier_done) && younger_held |=> out_valid)
    else $error("held op not released after completion");
  kind_a: assert property (out_valid |-> out_is_load || out_is_store)
    else $error("issued access has no kind");
  cover property (take_b ##1 barrier_busy [*3]);
  cover property (younger_held ##1 barrier_done);
  cover property (barrier_busy && out_valid && out_sync);
endmodule
bind memory_barrier_ordering memory_barrier_ordering_properties chk_u (
  .core_clk, .arst_n, .in_valid, .in_ready, .in_op, .in_instr, .in_cca, .in_shared,
  .out_valid, .out_is_load, .out_is_store, .out_sync, .out_instr, .ord_load_done,
  .ord_store_done, .gp_load_done, .gp_store_done, .barrier_busy, .barrier_done,
  .barrier_stype, .younger_held
);

//--- test/datapath_model.sv
// Purpose: stand-in for the datapath and memory side reporting progress
// Assumes: reports per kind in issue order, only synchronizable accesses
// Notes: lat sets the gap between report slots; zero answers every cycle
`timescale 1ns/1ps
module datapath_model
  import barrier_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic out_valid,
  input wire logic out_is_load,
  input wire logic out_is_store,
  input wire logic out_sync,
  input wire logic [7:0] lat,
  output logic ord_load_done,
  output logic ord_store_done,
  output logic gp_load_done,
  output logic gp_store_done,
  output logic idle
);
  logic [7:0] ol, os; // issued, short of the ordering point
  logic [7:0] gl, gs; // past the ordering point, not yet global
  logic [7:0] t; // slot pacing counter
  logic tick; // this cycle is a report slot
  assign idle = (ol | os | gl | gs) == 8'h0;
  // global report only follows an ordering report, never overtakes it
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {ol, os, gl, gs, t} = 40'h0;
      {ord_load_done, ord_store_done, gp_load_done, gp_store_done} <= 4'h0;
    end else begin
      tick = (t == 8'h0);
      t = (t >= lat) ? 8'h0 : t + 8'h1;
      gp_load_done <= tick && (gl != 8'h0);
      gp_store_done <= tick && (gs != 8'h0);
      ord_load_done <= tick && (ol != 8'h0);
      ord_store_done <= tick && (os != 8'h0);
      gl = gl - {7'h0, tick && (gl != 8'h0)};
      gs = gs - {7'h0, tick && (gs != 8'h0)};
      gl = gl + {7'h0, tick && (ol != 8'h0)};
      gs = gs + {7'h0, tick && (os != 8'h0)};
      ol = ol - {7'h0, tick && (ol != 8'h0)};
      os = os - {7'h0, tick && (os != 8'h0)};
      // only synchronizable accesses are tracked by the far side
      if (out_valid && out_sync) begin
        ol = ol + {7'h0, out_is_load};
        os = os + {7'h0, out_is_store};
      end
    end
  end
endmodule

//--- test/memory_barrier_ordering_test.sv
// Purpose: self-checking bench for the barrier block
// Assumes: the stand-in reports only synchronizable accesses
// Notes: each row issues an older load and store, a barrier, then one younger op
`timescale 1ns/1ps
module memory_barrier_ordering_test
  import barrier_pkg::*;
;
  logic core_clk = 1'b0, arst_n = 1'b0, in_valid = 1'b0, in_shared = 1'b0;
  logic [2:0] in_op = 3'h0;
  logic [31:0] in_instr = 32'h0, out_instr;
  logic [1:0] in_cca = 2'h0;
  logic [7:0] lat = 8'hc; // slow far side unless a test says otherwise
  logic in_ready, out_valid, out_is_load, out_is_store, out_sync, idle;
  logic ord_load_done, ord_store_done, gp_load_done, gp_store_done;
  logic barrier_busy, barrier_done, younger_held;
  logic [4:0] barrier_stype;
  int num_errors = 0, total_checks = 0;
  typedef struct packed {
    logic [4:0] ty; // barrier type
    logic [2:0] op; // younger op
    logic [1:0] cca; // younger access type
    logic [1:0] kind; // expected {store, load}
    logic held; // younger waits for completion
  } row_s;
  row_s rows [16] = '{
    '{5'h00, 3'h0, 2'h1, 2'h1, 1'b1}, '{5'h00, 3'h1, 2'h0, 2'h2, 1'b1},
    '{5'h04, 3'h0, 2'h1, 2'h1, 1'b0}, '{5'h04, 3'h2, 2'h1, 2'h3, 1'b1},
    '{5'h10, 3'h3, 2'h0, 2'h3, 1'b1}, '{5'h11, 3'h1, 2'h1, 2'h2, 1'b1},
    '{5'h12, 3'h0, 2'h1, 2'h1, 1'b0}, '{5'h12, 3'h1, 2'h0, 2'h2, 1'b1},
    '{5'h13, 3'h0, 2'h1, 2'h1, 1'b1}, '{5'h13, 3'h1, 2'h1, 2'h2, 1'b0},
    '{5'h01, 3'h4, 2'h1, 2'h3, 1'b1}, '{5'h0f, 3'h1, 2'h1, 2'h2, 1'b1},
    '{5'h14, 3'h0, 2'h0, 2'h1, 1'b1}, '{5'h1f, 3'h1, 2'h1, 2'h2, 1'b1},
    '{5'h00, 3'h0, 2'h2, 2'h1, 1'b0}, '{5'h05, 3'h1, 2'h3, 2'h2, 1'b0}
  };
  memory_barrier_ordering dut_u (
    .core_clk, .arst_n, .in_valid, .in_ready, .in_op, .in_instr, .in_cca, .in_shared,
    .out_valid, .out_is_load, .out_is_store, .out_sync, .out_instr, .ord_load_done,
    .ord_store_done, .gp_load_done, .gp_store_done, .barrier_busy, .barrier_done,
    .barrier_stype, .younger_held
  );
  datapath_model mem_u (
    .core_clk, .arst_n, .out_valid, .out_is_load, .out_is_store, .out_sync, .lat,
    .ord_load_done, .ord_store_done, .gp_load_done, .gp_store_done, .idle
  );
  always #5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a wait that ran out counts as a mismatch and ends the run
  task automatic stall_out();
    num_errors++;
    summarize();
  endtask
  // offer held steady until an edge sees it taken
  task automatic issue(input logic [2:0] op, input logic [31:0] ins, input logic [1:0] cca,
                       input logic sh);
    int n;
    n = 0;
    in_valid <= 1'b1;
    in_op <= op;
    in_instr <= ins;
    in_cca <= cca;
    in_shared <= sh;
    do begin
      @(posedge core_clk);
      n++;
    end while (!in_ready && n < 300);
    if (n >= 300)
      stall_out();
  endtask
  // older load and store, barrier, younger op; then drain everything
  task automatic run_row(input row_s r, input logic sh);
    logic seen_done, got;
    int n;
    seen_done = 1'b0;
    got = 1'b0;
    issue(3'h0, 32'h0, 2'h1, 1'b1);
    issue(3'h1, 32'h0, 2'h0, 1'b1);
    issue(3'h5, {21'h15a5a5, r.ty, 6'h2a}, 2'h1, 1'b1);
    issue(r.op, {27'h5a5a5a5, r.ty}, r.cca, sh);
    in_valid <= 1'b0;
    // a free younger op shows on the edge that takes it, so look there first
    #1;
    for (n = 0; n < 300 && !(got && seen_done); n++) begin
      if (barrier_done) begin
        seen_done = 1'b1;
        check(barrier_stype, r.ty);
        if (!(r.ty inside {5'h04, 5'h10, 5'h11, 5'h12, 5'h13}))
          check(idle, 1'b1);
      end
      if (out_valid && !got) begin
        got = 1'b1;
        check(seen_done, r.held);
        check({out_is_store, out_is_load}, r.kind);
        check(out_sync, sh && !r.cca[1]);
        check(out_instr, {27'h5a5a5a5, r.ty});
      end
      @(posedge core_clk);
      #1;
    end
    if (!(got && seen_done))
      stall_out();
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(idle && !barrier_busy) && n < 300);
    if (n >= 300)
      stall_out();
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    check({in_ready, barrier_busy, out_valid}, 3'h0); // outputs quiet in reset
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    foreach (rows[i])
      run_row(rows[i], 1'b1);
    run_row('{5'h00, 3'h0, 2'h1, 2'h1, 1'b0}, 1'b0);
    lat <= 8'h0;
    run_row(rows[1], 1'b1);
    lat <= 8'hc;
    // reset again with a barrier open and an op in the hold
    issue(3'h0, 32'h0, 2'h1, 1'b1);
    issue(3'h5, 32'h0, 2'h1, 1'b1);
    issue(3'h1, 32'h0, 2'h1, 1'b1);
    in_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check({younger_held, in_ready}, 2'h2);
    @(posedge core_clk);
    arst_n <= 1'b0;
    #1;
    check({barrier_busy, younger_held, in_ready, out_valid}, 4'h0);
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check(in_ready, 1'b1);
    @(posedge core_clk);
    run_row(rows[3], 1'b1);
    summarize();
  end
endmodule
